// ===== hdl/rtc_host_bus_and_pin_control.sv
// host bus, interrupt, square wave, storage clear and calendar of the clock
// Notes on behaviour
// RULE1 - static bus-type pin picks data-strobe/direction or separate read/write strobes
// RULE2 - cycle is address then data; address and ram select latch on strobe fall
// RULE3 - address latch ignores chip select
// RULE4 - data-strobe mode: drive read data after strobe rises
// RULE5 - data-strobe mode: capture write data on strobe fall
// RULE6 - data-strobe mode: direction high reads, low writes
// RULE7 - split mode: read strobe low enables bus drivers
// RULE8 - split mode: write data captured on write strobe rising edge
// RULE9 - host keeps chip select low and stable through the data phase
// RULE10 - interrupt pulled low while any enabled flag is set, also on backup
// RULE11 - reading register C releases the interrupt line
// RULE12 - square wave low unless enabled; else one of 13 rates, powered only
// RULE13 - raw 32k clock out when divider field 011 and both enables set
// RULE14 - latched ram select high reaches 128 extra bytes; low reaches clock; the code maps high onto memory entries 0x080-0x0ff
// RULE15 - storage clear sets all 242 storage bytes to ff, clock untouched
// RULE16 - clear input acts only after 125 ms low with main power
// RULE17 - reset pin low: interrupt released, bus refused, control bits cleared
// RULE18 - power failure blocks host writes; timekeeping continues
// RULE19 - periodic, alarm and update-ended events, each maskable
// RULE20 - seconds to years calendar with leap-year correction
// RULE21 - 14 clock/control bytes plus 242 storage bytes addressable
// RULE22 - crystal or external 32.768 kHz waveform is the timebase
// RULE23 - register C read clears every flag including the summary flag
// RULE24 - summary flag set on each enabled interrupt request
// RULE25 - strobes, clear and reset pins synchronised before use
// RULE26 - clear qualification restarts when the input returns high
`timescale 1ns/1ps
module rtc_host_bus_and_pin_control #(
    parameter int unsigned CLEAR_HOLD_CYC = rtc_pkg::CLEAR_HOLD_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic       bus_type_select_i,
    input  wire logic [7:0] mux_addr_data_i,
    input  wire logic       extended_ram_select_i,
    input  wire logic       address_strobe_i,
    input  wire logic       data_strobe_i,
    input  wire logic       read_write_i,
    input  wire logic       chip_select_n_i,
    input  wire logic       storage_clear_n_i,
    input  wire logic       reset_pin_n_i,
    input  wire logic       main_power_good_i,
    input  wire logic       crystal_inputs_i,
    output logic      [7:0] mux_addr_data_o,
    output logic            mux_addr_data_oe_o,
    output logic            irq_n_o,
    output logic            irq_n_oe_o,
    output logic            square_wave_out_o
);
    rtc_pkg::rtc_pins_type pin_raw;
    rtc_pkg::rtc_pins_type pin_s1_reg;
    rtc_pkg::rtc_pins_type sy;
    rtc_pkg::rtc_pins_type pv;
    rtc_pkg::rtc_clr_type  clr_state_reg;
    rtc_pkg::rtc_clr_type  clr_state_next;

    logic [7:0]           mem_reg [0:rtc_pkg::MEM_DEPTH-1];
    logic [7:0]           tm_reg  [0:9];
    logic [7:0]           addr_reg;
    logic                 addr_ext_reg;
    logic [6:0]           reg_a_reg;
    logic [7:0]           reg_b_reg;
    logic                 k32e_reg;
    logic                 pf_reg, af_reg, uf_reg, irq_summary_flag_reg;
    logic [7:0]           rdat_reg;
    logic                 oe_reg, irq_oe_reg, irq_lvl_reg, sqw_reg;
    logic [rtc_pkg::DIV_W-1:0] div_reg;
    logic                 tap_prev_reg, upd_pulse_reg;
    logic [rtc_pkg::CLR_CNT_W-1:0] clr_cnt_reg;
    logic [rtc_pkg::CLR_CNT_W-1:0] clr_cnt_next;
    logic [7:0]           clr_idx_reg;

    function automatic logic rd_level(input rtc_pkg::rtc_pins_type p);
        rd_level = p.rst_n & ~p.cs_n & (p.bts ? (p.rw & p.ds) : ~p.ds);
    endfunction

    function automatic logic [8:0] mem_index(input logic ext, input logic [7:0] a);
        mem_index = ext ? {2'h1, a[6:0]} : {1'b0, a};
    endfunction

    function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'h02:                      days_in = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
            8'h04, 8'h06, 8'h09, 8'h0b: days_in = 8'h1e;
            default:                    days_in = 8'h1f;
        endcase
    endfunction

    function automatic logic alarm_hit(input logic [7:0] al, input logic [7:0] t);
        alarm_hit = (al[7:6] == rtc_pkg::ALARM_ANY) || (al == t);
    endfunction

    // RULE25 pin synchroniser
    assign pin_raw = {bus_type_select_i, mux_addr_data_i, extended_ram_select_i, address_strobe_i,
                      data_strobe_i, read_write_i, chip_select_n_i, storage_clear_n_i,
                      reset_pin_n_i, main_power_good_i, crystal_inputs_i};

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_reg <= rtc_pkg::PINS_IDLE;
            sy         <= rtc_pkg::PINS_IDLE;
            pv         <= rtc_pkg::PINS_IDLE;
        end else begin
            pin_s1_reg <= pin_raw;
            sy         <= pin_s1_reg;
            pv         <= sy;
        end
    end

    // strobe decoding; stage two and three give edges without glitches
    wire       as_fall  = pv.as & ~sy.as;
    wire       rd_act   = rd_level(sy);
    wire       rd_start = rd_act & ~rd_level(pv);
    // RULE6 direction low marks a write
    wire       mot_wr   = pv.ds & ~sy.ds & ~sy.rw;
    wire       int_wr   = ~pv.rw & sy.rw;
    // RULE1 strobe convention select
    wire       wr_edge  = sy.bts ? mot_wr : int_wr;
    // RULE18 no writes on backup power
    wire       wr_en    = wr_edge & ~sy.cs_n & sy.pwr & sy.rst_n;
    wire [7:0] wr_data  = sy.ad;
    // RULE14 extended ram never reaches clock registers
    wire       is_clk   = ~addr_ext_reg & (addr_reg < rtc_pkg::STORE_FIRST);
    wire [8:0] idx      = mem_index(addr_ext_reg, addr_reg);
    wire       is_a     = is_clk & (addr_reg == rtc_pkg::REG_A);
    wire       is_b     = is_clk & (addr_reg == rtc_pkg::REG_B);
    wire       is_c     = is_clk & (addr_reg == rtc_pkg::REG_C);
    wire       is_tm    = is_clk & (addr_reg < rtc_pkg::NUM_TIME);
    wire       rd_c_clr = rd_start & is_c;
    wire [7:0] reg_c    = {irq_summary_flag_reg, pf_reg, af_reg, uf_reg, 3'h0, k32e_reg};
    // RULE21 clock, control and storage map
    wire [7:0] rd_word  = !is_clk ? mem_reg[idx] :
                          is_tm   ? tm_reg[addr_reg[3:0]] :
                          is_a    ? {1'b0, reg_a_reg} :
                          is_b    ? reg_b_reg :
                          is_c    ? reg_c : {sy.pwr, 7'h00};

    // RULE2 address phase
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_reg     <= 8'h00;
            addr_ext_reg <= 1'b0;
        // RULE3 no chip select term
        end else if (as_fall) begin
            addr_reg     <= sy.ad;
            addr_ext_reg <= sy.ext;
        end
    end

    // RULE4 drive after strobe rise
    // RULE7 read strobe enables drivers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oe_reg   <= 1'b0;
            rdat_reg <= 8'h00;
        end else begin
            oe_reg   <= rd_act;
            rdat_reg <= rd_start ? rd_word : rdat_reg;
        end
    end

    localparam int B_RANGE_HI = rtc_pkg::B_PIE;

    // RULE5 capture on strobe fall
    // RULE8 capture on write strobe rise
    // RULE17 reset pin clears enables
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_a_reg <= 7'h00;
            reg_b_reg <= 8'h00;
            k32e_reg  <= 1'b0;
        end else if (!sy.rst_n) begin
            reg_b_reg[B_RANGE_HI:rtc_pkg::B_SQUARE_WAVE_ENABLE] <= 4'h0;
        end else if (wr_en) begin
            if (is_a) reg_a_reg <= wr_data[6:0];
            if (is_b) reg_b_reg <= wr_data;
            if (is_c) k32e_reg  <= wr_data[0];
        end
    end

    // RULE22 timebase from x1, crystal or waveform alike
    wire [2:0] osc     = reg_a_reg[rtc_pkg::OSC_MSB:rtc_pkg::OSC_LSB];
    wire [3:0] rs      = reg_a_reg[3:0];
    wire       running = (osc == rtc_pkg::OSC_RUN) | (osc == rtc_pkg::OSC_32K);
    wire       x1_rise = sy.x1 & ~pv.x1;
    wire       sec_tick = x1_rise & running & (&div_reg);
    wire [3:0] tap_sel = (rs < rtc_pkg::RS_SHORT) ? rs + rtc_pkg::TAP_LOW : rs - rtc_pkg::TAP_SKIP;
    wire       tap     = div_reg[tap_sel] & (rs != 4'h0);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_reg       <= '0;
            tap_prev_reg  <= 1'b0;
            upd_pulse_reg <= 1'b0;
        end else begin
            div_reg       <= !running ? '0 : div_reg + {{(rtc_pkg::DIV_W-1){1'b0}}, x1_rise};
            tap_prev_reg  <= tap;
            upd_pulse_reg <= sec_tick;
        end
    end

    // RULE12 rate or low, powered only
    // RULE13 raw oscillator passthrough
    wire sqw_next = sy.pwr & reg_b_reg[rtc_pkg::B_SQUARE_WAVE_ENABLE] &
                    ((osc == rtc_pkg::OSC_32K && k32e_reg) ? sy.x1 : tap);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) sqw_reg <= 1'b0;
        else          sqw_reg <= sqw_next;
    end

    // RULE20 binary 24-hour calendar
    wire sec_wrap = tm_reg[rtc_pkg::T_SEC] == rtc_pkg::SEC_MAX;
    wire min_wrap = tm_reg[rtc_pkg::T_MIN] == rtc_pkg::SEC_MAX;
    wire hr_wrap  = tm_reg[rtc_pkg::T_HR] == rtc_pkg::HR_MAX;
    wire dom_wrap = tm_reg[rtc_pkg::T_DOM] >= days_in(tm_reg[rtc_pkg::T_MON], tm_reg[rtc_pkg::T_YR]);
    wire mon_wrap = tm_reg[rtc_pkg::T_MON] >= rtc_pkg::MON_MAX;
    wire dow_wrap = tm_reg[rtc_pkg::T_DOW] >= rtc_pkg::DOW_MAX;
    wire yr_wrap  = tm_reg[rtc_pkg::T_YR] >= rtc_pkg::YR_MAX;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 10; i++) tm_reg[i] <= 8'h00;
        end else begin
            if (sec_tick) begin
                tm_reg[rtc_pkg::T_SEC] <= sec_wrap ? 8'h00 : tm_reg[rtc_pkg::T_SEC] + 8'h01;
                if (sec_wrap) tm_reg[rtc_pkg::T_MIN] <= min_wrap ? 8'h00 : tm_reg[rtc_pkg::T_MIN] + 8'h01;
                if (sec_wrap && min_wrap) begin
                    tm_reg[rtc_pkg::T_HR] <= hr_wrap ? 8'h00 : tm_reg[rtc_pkg::T_HR] + 8'h01;
                    if (hr_wrap) begin
                        tm_reg[rtc_pkg::T_DOW] <= dow_wrap ? rtc_pkg::FIRST_DAY : tm_reg[rtc_pkg::T_DOW] + 8'h01;
                        tm_reg[rtc_pkg::T_DOM] <= dom_wrap ? rtc_pkg::FIRST_DAY : tm_reg[rtc_pkg::T_DOM] + 8'h01;
                        if (dom_wrap) begin
                            tm_reg[rtc_pkg::T_MON] <= mon_wrap ? rtc_pkg::FIRST_DAY : tm_reg[rtc_pkg::T_MON] + 8'h01;
                            if (mon_wrap) tm_reg[rtc_pkg::T_YR] <= yr_wrap ? 8'h00 : tm_reg[rtc_pkg::T_YR] + 8'h01;
                        end
                    end
                end
            end
            // host write wins over a coincident tick
            if (wr_en && is_tm) tm_reg[addr_reg[3:0]] <= wr_data;
        end
    end

    // RULE19 three maskable events
    wire per_set = tap & ~tap_prev_reg & running;
    wire upd_set = upd_pulse_reg;
    wire alm_set = upd_pulse_reg &
                   alarm_hit(tm_reg[rtc_pkg::T_SEC_AL], tm_reg[rtc_pkg::T_SEC]) &
                   alarm_hit(tm_reg[rtc_pkg::T_MIN_AL], tm_reg[rtc_pkg::T_MIN]) &
                   alarm_hit(tm_reg[rtc_pkg::T_HR_AL], tm_reg[rtc_pkg::T_HR]);
    wire [2:0] sets = {per_set, alm_set, upd_set};
    wire [2:0] ens  = reg_b_reg[rtc_pkg::B_PIE:rtc_pkg::B_UIE];
    // RULE24 summary on enabled request
    wire irq_summary_flag_set = |(sets & ens);
    // RULE23 read clears, set wins
    wire [3:0] flags_next = !sy.rst_n ? 4'h0 :
                            {irq_summary_flag_set, sets} | ({irq_summary_flag_reg, pf_reg, af_reg, uf_reg} & {4{~rd_c_clr}});

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {irq_summary_flag_reg, pf_reg, af_reg, uf_reg} <= 4'h0;
            irq_oe_reg  <= 1'b0;
            irq_lvl_reg <= 1'b0;
        end else begin
            {irq_summary_flag_reg, pf_reg, af_reg, uf_reg} <= flags_next;
            // RULE10 pull low on enabled flag
            // RULE11 release follows the flag clear
            irq_oe_reg  <= |(flags_next[2:0] & ens);
            irq_lvl_reg <= 1'b0;
        end
    end

    localparam int unsigned CLR_LAST = CLEAR_HOLD_CYC - 1;

    // RULE16 long-low qualification
    // RULE26 restart when released
    always_comb begin
        clr_state_next = clr_state_reg;
        clr_cnt_next   = '0;
        case (clr_state_reg)
            rtc_pkg::CLR_IDLE:
                if (!sy.rcl_n && sy.pwr) clr_state_next = rtc_pkg::CLR_QUAL;
            rtc_pkg::CLR_QUAL:
                if (sy.rcl_n || !sy.pwr) clr_state_next = rtc_pkg::CLR_IDLE;
                else if (clr_cnt_reg == CLR_LAST[rtc_pkg::CLR_CNT_W-1:0]) clr_state_next = rtc_pkg::CLR_SWEEP;
                else clr_cnt_next = clr_cnt_reg + 1'b1;
            rtc_pkg::CLR_SWEEP:
                if (clr_idx_reg == rtc_pkg::STORE_LAST) clr_state_next = rtc_pkg::CLR_HOLD;
            rtc_pkg::CLR_HOLD:
                if (sy.rcl_n) clr_state_next = rtc_pkg::CLR_IDLE;
            default:
                clr_state_next = rtc_pkg::CLR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clr_state_reg <= rtc_pkg::CLR_IDLE;
            clr_cnt_reg   <= '0;
            clr_idx_reg   <= rtc_pkg::STORE_FIRST;
        end else begin
            clr_state_reg <= clr_state_next;
            clr_cnt_reg   <= clr_cnt_next;
            clr_idx_reg   <= (clr_state_reg == rtc_pkg::CLR_SWEEP) ? clr_idx_reg + 8'h01 : rtc_pkg::STORE_FIRST;
        end
    end

    // RULE15 one storage byte per cycle; host storage writes lost meanwhile
    always_ff @(posedge clk_sys_i) begin
        if (clr_state_reg == rtc_pkg::CLR_SWEEP) mem_reg[{1'b0, clr_idx_reg}] <= rtc_pkg::ERASED;
        else if (wr_en && !is_clk) mem_reg[idx] <= wr_data;
    end

    assign mux_addr_data_o    = rdat_reg;
    assign mux_addr_data_oe_o = oe_reg;
    assign irq_n_o            = irq_lvl_reg;
    assign irq_n_oe_o         = irq_oe_reg;
    assign square_wave_out_o  = sqw_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    property p_addr_latch;
        as_fall |=> addr_reg == $past(sy.ad) && addr_ext_reg == $past(sy.ext);
    endproperty
    a_addr_latch: assert property (p_addr_latch) // RULE3
        else $error("address not latched on strobe fall");

    property p_mot_oe;
        sy.bts && rd_act |=> mux_addr_data_oe_o;
    endproperty
    a_mot_oe: assert property (p_mot_oe) // RULE4
        else $error("read data not driven after strobe rise");

    property p_int_oe;
        !sy.bts && rd_act |=> mux_addr_data_oe_o && mux_addr_data_o == $past(rd_start ? rd_word : rdat_reg);
    endproperty
    a_int_oe: assert property (p_int_oe) // RULE7
        else $error("read strobe did not enable drivers");

    property p_mot_wr;
        sy.bts && wr_en && is_a |=> reg_a_reg == $past(sy.ad[6:0]);
    endproperty
    a_mot_wr: assert property (p_mot_wr) // RULE5
        else $error("strobe-fall write lost");

    property p_int_wr;
        !sy.bts && ~pv.rw && sy.rw && !sy.cs_n && sy.pwr && sy.rst_n && is_b
            |=> reg_b_reg == $past(sy.ad);
    endproperty
    a_int_wr: assert property (p_int_wr) // RULE8
        else $error("write strobe rise did not capture");

    property p_c_clear;
        rd_c_clr && sets == 3'h0 |=> {irq_summary_flag_reg, pf_reg, af_reg, uf_reg} == 4'h0 && !irq_n_oe_o;
    endproperty
    a_c_clear: assert property (p_c_clear) // RULE23
        else $error("status read left a flag or the line set");

    property p_irq_on;
        sy.rst_n && |(sets & ens) |=> irq_n_oe_o && irq_summary_flag_reg;
    endproperty
    a_irq_on: assert property (p_irq_on) // RULE10
        else $error("enabled event did not pull the line");

    property p_sqw_low;
        !reg_b_reg[rtc_pkg::B_SQUARE_WAVE_ENABLE] |=> !square_wave_out_o;
    endproperty
    a_sqw_low: assert property (p_sqw_low) // RULE12
        else $error("square wave not held low");

    property p_rst_pin;
        !sy.rst_n |=> !irq_n_oe_o && !mux_addr_data_oe_o;
    endproperty
    a_rst_pin: assert property (p_rst_pin) // RULE17
        else $error("reset pin did not release outputs");

    property p_pwr_block;
        !sy.pwr && sy.rst_n |=> $stable(reg_a_reg) && $stable(tm_reg[rtc_pkg::T_SEC_AL]);
    endproperty
    a_pwr_block: assert property (p_pwr_block) // RULE18
        else $error("write accepted without main power");

    property p_clr_qual;
        $rose(clr_state_reg == rtc_pkg::CLR_SWEEP) |-> $past(clr_cnt_reg) == CLR_LAST;
    endproperty
    a_clr_qual: assert property (p_clr_qual) // RULE16
        else $error("clear started before full hold time");

    property p_clr_restart;
        clr_state_reg == rtc_pkg::CLR_QUAL && sy.rcl_n |=> clr_cnt_reg == '0 && clr_state_reg == rtc_pkg::CLR_IDLE;
    endproperty
    a_clr_restart: assert property (p_clr_restart) // RULE26
        else $error("clear count not restarted");

    c_status_read: cover property (rd_c_clr && irq_summary_flag_reg);
    c_sweep: cover property (clr_state_reg == rtc_pkg::CLR_SWEEP);
    c_mot_write: cover property (wr_en && sy.bts);
    c_alarm: cover property (alm_set);
endmodule // rtc_host_bus_and_pin_control

// ===== include/rtc_pkg.sv
// constants and types shared by the real-time clock pin controller
package rtc_pkg;
    localparam int CLK_KHZ        = 50000;
    localparam int CLEAR_HOLD_MS  = 125;
    localparam int CLEAR_HOLD_CYC = CLEAR_HOLD_MS * CLK_KHZ;
    localparam int CLR_CNT_W      = 23;
    localparam int DIV_W          = 15;
    localparam int MEM_DEPTH      = 384;

    localparam logic [7:0] NUM_TIME    = 8'h0a;
    localparam logic [7:0] REG_A       = 8'h0a;
    localparam logic [7:0] REG_B       = 8'h0b;
    localparam logic [7:0] REG_C       = 8'h0c;
    localparam logic [7:0] STORE_FIRST = 8'h0e;
    localparam logic [7:0] STORE_LAST  = 8'hff;
    localparam logic [7:0] ERASED      = 8'hff;

    localparam int T_SEC = 0, T_SEC_AL = 1, T_MIN = 2, T_MIN_AL = 3, T_HR = 4;
    localparam int T_HR_AL = 5, T_DOW = 6, T_DOM = 7, T_MON = 8, T_YR = 9;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] HR_MAX  = 8'h17;
    localparam logic [7:0] DOW_MAX = 8'h07;
    localparam logic [7:0] MON_MAX = 8'h0c;
    localparam logic [7:0] YR_MAX  = 8'h63;
    localparam logic [7:0] FIRST_DAY = 8'h01;
    localparam logic [1:0] ALARM_ANY = 2'h3;

    localparam int B_PIE = 6, B_AIE = 5, B_UIE = 4, B_SQUARE_WAVE_ENABLE = 3;
    localparam int OSC_MSB = 6, OSC_LSB = 4;
    localparam logic [2:0] OSC_RUN = 3'h2;
    localparam logic [2:0] OSC_32K = 3'h3;
    localparam logic [3:0] RS_SHORT = 4'h3;
    localparam logic [3:0] TAP_LOW  = 4'h5;
    localparam logic [3:0] TAP_SKIP = 4'h2;

    typedef struct packed {
        logic       bts;
        logic [7:0] ad;
        logic       ext;
        logic       as;
        logic       ds;
        logic       rw;
        logic       cs_n;
        logic       rcl_n;
        logic       rst_n;
        logic       pwr;
        logic       x1;
    } rtc_pins_type;
    localparam rtc_pins_type PINS_IDLE = 18'h0001c;

    typedef enum logic [1:0] {
        CLR_IDLE  = 2'h0,
        CLR_QUAL  = 2'h1,
        CLR_SWEEP = 2'h3,
        CLR_HOLD  = 2'h2
    } rtc_clr_type;
endpackage

// ===== verif/rtc_host_model.sv
// host processor model driving the clock's multiplexed bus pins
`timescale 1ns/1ps
module rtc_host_model (
    input  wire logic       clk_i,
    input  wire logic       mode_i,
    input  wire logic [7:0] data_i,
    input  wire logic       oe_i,
    output logic      [7:0] ad_o,
    output logic            ext_o,
    output logic            as_o,
    output logic            ds_o,
    output logic            rw_o,
    output logic            cs_n_o
);
    initial begin
        ad_o = 8'h00;
        ext_o = 1'b0;
        as_o = 1'b0;
        ds_o = 1'b0;
        rw_o = 1'b1;
        cs_n_o = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic addr(input logic [8:0] a);
        // idle strobe level differs per mode: low for data strobe, high for read strobe
        ds_o = ~mode_i;
        ad_o = a[7:0];
        ext_o = a[8];
        as_o = 1'b1;
        step(4);
        as_o = 1'b0;
        step(4);
        ad_o = ~a[7:0];
    endtask
    // strobes per fixed mode, select held through data phase
    task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic cs_n);
        addr(a);
        ad_o = d;
        cs_n_o = cs_n;
        rw_o = 1'b0;
        ds_o = 1'b1;
        step(4);
        if (mode_i) ds_o = 1'b0;
        else rw_o = 1'b1;
        step(4);
        cs_n_o = 1'b1;
        rw_o = 1'b1;
        ad_o = ~d;
        step(4);
    endtask
    // read: released bus shows the inverse of the last value
    task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic oe);
        addr(a);
        cs_n_o = 1'b0;
        ds_o = ~ds_o;
        step(6);
        d = data_i;
        oe = oe_i;
        ds_o = ~ds_o;
        step(4);
        cs_n_o = 1'b1;
        step(4);
    endtask
endmodule // rtc_host_model

// ===== verif/rtc_host_bus_and_pin_control_tb_top.sv
// self-checking bench for the clock's host bus and pin control
`timescale 1ns/1ps
module rtc_host_bus_and_pin_control_tb_top;
    logic       clk_sys_i, rst_b_i, mode, pwr, rcl_n, rpin_n, x1;
    logic [7:0] h_ad, d_ad, d, a_in;
    logic       h_ext, h_as, h_ds, h_rw, h_cs_n, oe, irq, irq_oe, square_wave_out, got;
    logic [8:0] a;
    int         mismatches = 0, num_checks = 0, cyc = 0, tog;
    int         mem[int];
    int unsigned rng = 65305;
    assign a_in = oe ? d_ad : h_ad;
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // timebase far faster than real so low divider taps toggle quickly; phase unrelated
    initial begin
        x1 = 1'b0;
        forever #97 x1 = ~x1;
    end
    rtc_host_model host (.clk_i(clk_sys_i), .mode_i(mode), .data_i(d_ad), .oe_i(oe), .ad_o(h_ad),
        .ext_o(h_ext), .as_o(h_as), .ds_o(h_ds), .rw_o(h_rw), .cs_n_o(h_cs_n));
    rtc_host_bus_and_pin_control #(.CLEAR_HOLD_CYC(20)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .bus_type_select_i(mode), .mux_addr_data_i(a_in), .extended_ram_select_i(h_ext),
        .address_strobe_i(h_as), .data_strobe_i(h_ds), .read_write_i(h_rw), .chip_select_n_i(h_cs_n),
        .storage_clear_n_i(rcl_n), .reset_pin_n_i(rpin_n), .main_power_good_i(pwr),
        .crystal_inputs_i(x1), .mux_addr_data_o(d_ad), .mux_addr_data_oe_o(oe), .irq_n_o(irq),
        .irq_n_oe_o(irq_oe), .square_wave_out_o(square_wave_out));
    function automatic int unsigned xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input string n, input int e, input logic [7:0] g);
        num_checks++;
        if (g !== e[7:0]) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e[7:0], g);
        end
    endtask
    task automatic wrm(input logic [8:0] a, input logic [7:0] v, input logic cs_n = 0);
        host.wr(a, v, cs_n);
        if (!cs_n && pwr) mem[a] = v;
    endtask
    task automatic rdm(input logic [8:0] a, input int e);
        host.rd(a, d, got);
        chk("read oe", 1, {7'h0, got});
        chk("read data", e, d);
    endtask
    task automatic watch(input int n);
        tog = 0;
        repeat (n) begin
            got = square_wave_out;
            @(negedge clk_sys_i);
            if (square_wave_out !== got) tog++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        rst_b_i = 1'b0;
        mode = 1'b1;
        pwr = 1'b1;
        rcl_n = 1'b1;
        rpin_n = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        rst_b_i = 1;
        host.step(6);
        for (int m = 1; m >= 0; m--) begin
            if (m == 0) begin
                rst_b_i = 0;
                mode = 0;
                host.step(10);
                rst_b_i = 1;
                host.step(6);
            end
            for (int i = 0; i < 4; i++) begin
                a = 9'(14 + xs() % 242);
                wrm(a, 8'(xs()));
                rdm(a, mem[a]);
            end
            wrm(a, ~8'(mem[a]), 1'b1);
            rdm(a, mem[a]);
            pwr = 0;
            wrm(a, 8'h5a);
            pwr = 1;
            host.step(4);
            rdm(a, mem[a]);
            wrm(9'h185, 8'(xs()));
            rdm(9'h185, mem[9'h185]);
            $display("bus test in mode %0d done", m);
        end
        wrm(9'h00a, 8'h23);
        wrm(9'h00b, 8'h48);
        for (int i = 0; i < 3000 && irq_oe !== 1'b1; i++) host.step(1);
        chk("irq asserted", 1, {7'h0, irq_oe});
        chk("irq level", 0, {7'h0, irq});
        watch(300);
        chk("sqw toggles", 1, {7'h0, tog > 2});
        // slowest rate: no fresh periodic flag can race the status read
        wrm(9'h00a, 8'h2f);
        rdm(9'h00c, 8'hc0);
        chk("c flags", 8'hc0, d & 8'hc0);
        chk("irq released", 0, {7'h0, irq_oe});
        host.step(100);
        host.rd(9'h00c, d, got);
        chk("summary unset", 0, d & 8'h80);
        wrm(9'h00b, 8'h00);
        watch(300);
        chk("sqw held low", 0, {7'h0, tog > 0 || square_wave_out !== 1'b0});
        wrm(9'h00a, 8'h33);
        wrm(9'h00c, 8'h01);
        wrm(9'h00b, 8'h48);
        watch(300);
        chk("raw clock out", 1, {7'h0, tog > 40});
        rpin_n = 0;
        host.step(6);
        chk("reset irq off", 0, {7'h0, irq_oe});
        host.rd(a, d, got);
        chk("reset refused", 0, {7'h0, got});
        rpin_n = 1;
        $display("interrupt and square wave tests done");
        rcl_n = 0;
        host.step(12);
        rcl_n = 1;
        host.step(4);
        rcl_n = 0;
        host.step(14);
        rcl_n = 1;
        host.step(6);
        rdm(a, mem[a]);
        rcl_n = 0;
        host.step(320);
        rcl_n = 1;
        host.step(6);
        rdm(a, 8'hff);
        rdm(9'h00e, 8'hff);
        rdm(9'h00a, 8'h33);
        $display("storage clear test done");
        report_and_stop();
    end
endmodule // rtc_host_bus_and_pin_control_tb_top
